// File: rtl/swdcl_pkg.sv
package swdcl_pkg;

  // top-level sequencer states, one-hot
  typedef enum logic [6:0]
  {
    ST_CODE  = 7'h01,  // receiving a command code
    ST_FIELD = 7'h02,  // moving an address, data or status field
    ST_DELAY = 7'h04,  // delay slot, target access happens here
    ST_SYNCW = 7'h08,  // probe seen, waiting for the line to rise
    ST_SYNCH = 7'h10,  // hold-off before answering the probe
    ST_SYNCL = 7'h20,  // driving the timed low pulse
    ST_SYNCP = 7'h40   // one-cycle high speedup
  } swdcl_state_t;

  // field phases of a command
  localparam logic [2:0] PH_END  = 3'h0;
  localparam logic [2:0] PH_RXA  = 3'h1;  // 16-bit address in
  localparam logic [2:0] PH_RX8  = 3'h2;  // 8-bit data in
  localparam logic [2:0] PH_RX16 = 3'h3;  // 16-bit data in
  localparam logic [2:0] PH_DLY  = 3'h4;  // delay slot
  localparam logic [2:0] PH_TXS  = 3'h5;  // status byte out
  localparam logic [2:0] PH_TX8  = 3'h6;  // 8-bit data out
  localparam logic [2:0] PH_TX16 = 3'h7;  // 16-bit data out

  // command codes
  localparam logic [7:0] CMD_ACK_ON      = 8'hD5;
  localparam logic [7:0] CMD_ACK_OFF     = 8'hD6;
  localparam logic [7:0] CMD_HALT        = 8'h90;
  localparam logic [7:0] CMD_STAT_GET    = 8'hE4;
  localparam logic [7:0] CMD_CTRL_SET    = 8'hC4;
  localparam logic [7:0] CMD_MEM_FETCH   = 8'hE0;
  localparam logic [7:0] CMD_MEM_FETCH_S = 8'hE1;
  localparam logic [7:0] CMD_REFETCH_S   = 8'hE8;
  localparam logic [7:0] CMD_MEM_STORE   = 8'hC0;
  localparam logic [7:0] CMD_MEM_STORE_S = 8'hC1;
  localparam logic [7:0] CMD_MATCH_GET   = 8'hE2;
  localparam logic [7:0] CMD_MATCH_SET   = 8'hC2;
  localparam logic [7:0] CMD_RESUME      = 8'h08;
  localparam logic [7:0] CMD_STEP        = 8'h10;
  localparam logic [7:0] CMD_RESUME_TAG  = 8'h18;
  localparam logic [7:0] CMD_GET_ACC     = 8'h68;
  localparam logic [7:0] CMD_GET_FLAGS   = 8'h69;
  localparam logic [7:0] CMD_GET_PC      = 8'h6B;
  localparam logic [7:0] CMD_GET_IDX     = 8'h6C;
  localparam logic [7:0] CMD_GET_SP      = 8'h6F;
  localparam logic [7:0] CMD_FETCH_INC   = 8'h70;
  localparam logic [7:0] CMD_FETCH_INC_S = 8'h71;
  localparam logic [7:0] CMD_SET_ACC     = 8'h48;
  localparam logic [7:0] CMD_SET_FLAGS   = 8'h49;
  localparam logic [7:0] CMD_SET_PC      = 8'h4B;
  localparam logic [7:0] CMD_SET_IDX     = 8'h4C;
  localparam logic [7:0] CMD_SET_SP      = 8'h4F;
  localparam logic [7:0] CMD_STORE_INC   = 8'h50;
  localparam logic [7:0] CMD_STORE_INC_S = 8'h51;

  // processor register selects on the write strobe
  localparam logic [2:0] REG_ACC   = 3'h0;
  localparam logic [2:0] REG_FLAGS = 3'h1;
  localparam logic [2:0] REG_PC    = 3'h2;
  localparam logic [2:0] REG_IDX   = 3'h3;
  localparam logic [2:0] REG_SP    = 3'h4;

  // status/control register layout
  localparam int         STAT_ENABLE_BIT = 7;      // debug mode enable
  localparam int         STAT_HALTED_BIT = 6;      // read-only halted flag
  localparam logic [7:0] STAT_RESET      = 8'h00;
  localparam logic [15:0] MATCH_RESET    = 16'h0000;

  // timing, in debug clock cycles
  localparam logic [7:0] BIT_CYC     = 8'h10;            // one serial bit
  localparam logic [7:0] BIT_END     = BIT_CYC - 8'h02;  // re-arm before next edge
  localparam logic [7:0] RX_SAMPLE   = 8'h0A;            // host bit sampled here
  localparam logic [7:0] TX1_SPEEDUP = 8'h07;            // high pulse for a 1
  localparam logic [7:0] TX0_LOW     = 8'h0D;            // low drive for a 0
  localparam logic [7:0] DELAY_CYC   = 8'h10;            // delay slot
  localparam logic [9:0] TIMEOUT_CYC = 10'h200;          // between host edges
  localparam logic [7:0] SYNC_DETECT = 8'h80;            // long low = probe
  localparam logic [7:0] SYNC_HOLD   = 8'h10;            // hold-off before answer
  localparam logic [7:0] SYNC_LOW    = 8'h80;            // answer low time

endpackage

// File: rtl/swdcl_cmd_layer.sv
`timescale 1ns/100ps

// How it works
// - every command but the probe opens with an 8-bit code, msb first
// - a delay slot is 16 debug clocks; the target access runs inside it
// - address 16 bits in, byte data 8 bits, wide data 16 bits
// - status field sends the status/control register; control field writes it
// - the speed probe has no code and only yields a timed pulse
// - code 90 plus delay halts the processor, ignored when enable bit is 0
// - E4 returns the status byte; C4 writes one control byte
// - E0 address, delay, memory byte; E1 adds status before the byte
// - E8 returns status then re-reads the last read address
// - C0 address and byte, write, delay; C1 adds status after the delay
// - E2 returns the 16-bit match register, C2 loads it, no delay slot
// - 08 and 18 with delay resume at the program counter, halted only
// - 10 with delay runs one instruction then halts again
// - 68/69 return acc and flags byte; 6B/6C/6F return pc, index, sp
// - 48/49 write acc and flags; 4B/4C/4F set_prog_counter_cmd, index, sp; then delay
// - 70 bumps the index pair and returns its byte; 71 adds status first
// - 50 bumps the index pair and stores the byte there; 51 adds status
// - D5 and D6 with delay turn the acknowledge handshake on and off
// - after a probe, wait for the line high then hold off 16 clocks
// - answer low for 128 clocks, high for 1, then release
// - halted commands only while stopped; the rest at any time
// - 16 clocks per bit, msb first, each bit opened by a host falling edge
// - 512 clocks without a host edge aborts the command with no side effect
module swdcl_cmd_layer
  import swdcl_pkg::*;
(
  input  wire logic        clk,          // debug clock
  input  wire logic        reset,        // async, active high
  input  wire logic        pin_in,       // debug_wire_pin level seen
  output logic             pin_out,      // level driven on the pin
  output logic             pin_oe,       // high while we drive the pin
  output logic             mem_req,      // memory access request, held to ack
  output logic             mem_we,       // 1 = write, 0 = read
  output logic [15:0]      mem_addr,     // memory address
  output logic [7:0]       mem_wdata,    // memory write byte
  input  wire logic [7:0]  mem_rdata,    // memory read byte, valid with ack
  input  wire logic        mem_ack,      // access done
  input  wire logic        cpu_halted,   // processor in halted_debug_state
  input  wire logic [7:0]  cpu_acc,      // accumulator
  input  wire logic [7:0]  cpu_flags,    // condition_flags
  input  wire logic [15:0] cpu_pc,       // program counter
  input  wire logic [15:0] cpu_hx,       // index pair
  input  wire logic [15:0] cpu_sp,       // stack pointer
  output logic             halt_req,     // pulse: enter halted state
  output logic             go_req,       // pulse: resume at pc
  output logic             step_req,     // pulse: one instruction, then halt
  output logic             reg_wr,       // pulse: processor register write
  output logic [2:0]       reg_sel,      // which register
  output logic [15:0]      reg_wdata,    // value to write
  output logic [7:0]       status_ctrl,  // debug_status_control_reg contents
  output logic [15:0]      match_addr,   // debug_breakpoint_reg contents
  output logic             ack_enable    // acknowledge handshake on
);

  // field sequence of each command; unknown codes end at once
  function automatic logic [2:0] cmd_phase(input logic [7:0] c, input logic [2:0] s);
    logic [11:0] seq;
    seq = {PH_END, PH_END, PH_END, PH_END};
    case (c)
      CMD_HALT, CMD_RESUME, CMD_RESUME_TAG, CMD_STEP,
      CMD_ACK_ON, CMD_ACK_OFF:           seq = {PH_END, PH_END, PH_END, PH_DLY};
      CMD_STAT_GET:                      seq = {PH_END, PH_END, PH_END, PH_TXS};
      CMD_CTRL_SET:                      seq = {PH_END, PH_END, PH_END, PH_RX8};
      CMD_MEM_FETCH:                     seq = {PH_END, PH_TX8, PH_DLY, PH_RXA};
      CMD_MEM_FETCH_S:                   seq = {PH_TX8, PH_TXS, PH_DLY, PH_RXA};
      CMD_REFETCH_S:                     seq = {PH_END, PH_END, PH_TX8, PH_TXS};
      CMD_MEM_STORE:                     seq = {PH_END, PH_DLY, PH_RX8, PH_RXA};
      CMD_MEM_STORE_S:                   seq = {PH_TXS, PH_DLY, PH_RX8, PH_RXA};
      CMD_MATCH_GET:                     seq = {PH_END, PH_END, PH_END, PH_TX16};
      CMD_MATCH_SET:                     seq = {PH_END, PH_END, PH_END, PH_RX16};
      CMD_GET_ACC, CMD_GET_FLAGS,
      CMD_FETCH_INC:                     seq = {PH_END, PH_END, PH_TX8, PH_DLY};
      CMD_FETCH_INC_S:                   seq = {PH_END, PH_TX8, PH_TXS, PH_DLY};
      CMD_GET_PC, CMD_GET_IDX,
      CMD_GET_SP:                        seq = {PH_END, PH_END, PH_TX16, PH_DLY};
      CMD_SET_ACC, CMD_SET_FLAGS,
      CMD_STORE_INC:                     seq = {PH_END, PH_END, PH_DLY, PH_RX8};
      CMD_STORE_INC_S:                   seq = {PH_END, PH_TXS, PH_DLY, PH_RX8};
      CMD_SET_PC, CMD_SET_IDX,
      CMD_SET_SP:                        seq = {PH_END, PH_END, PH_DLY, PH_RX16};
      default:                           seq = {PH_END, PH_END, PH_END, PH_END};
    endcase
    case (s)
      3'h0:    cmd_phase = seq[2:0];
      3'h1:    cmd_phase = seq[5:3];
      3'h2:    cmd_phase = seq[8:6];
      3'h3:    cmd_phase = seq[11:9];
      default: cmd_phase = PH_END;
    endcase
  endfunction

  // commands that need the processor stopped
  function automatic logic halted_only(input logic [7:0] c);
    case (c)
      CMD_RESUME, CMD_RESUME_TAG, CMD_STEP, CMD_GET_ACC, CMD_GET_FLAGS,
      CMD_GET_PC, CMD_GET_IDX, CMD_GET_SP, CMD_FETCH_INC, CMD_FETCH_INC_S,
      CMD_SET_ACC, CMD_SET_FLAGS, CMD_SET_PC, CMD_SET_IDX, CMD_SET_SP,
      CMD_STORE_INC, CMD_STORE_INC_S: halted_only = 1'b1;
      default:                        halted_only = 1'b0;
    endcase
  endfunction

  swdcl_state_t st_q, st_d;
  logic        pin_m_q, pin_s_q, pin_p_q;
  logic [7:0]  cmd_q, cmd_d;
  logic [2:0]  step_q, step_d;
  logic [4:0]  nbits_q, nbits_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        bit_q, bit_d;
  logic [9:0]  tmo_q;
  logic [7:0]  low_q;
  logic        oe_d, out_d;
  logic [15:0] addr_q, last_q, data_q, res_q;
  logic [7:0]  stat_q;
  logic [15:0] match_q;

  // pin synchroniser; only pin_s_q and its delayed copy are looked at
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      pin_m_q <= 1'b1;
      pin_s_q <= 1'b1;
      pin_p_q <= 1'b1;
    end
    else
    begin
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end

  // sequencing decode
  wire        fell      = pin_p_q & ~pin_s_q;
  wire [2:0]  phase     = cmd_phase(cmd_q, step_q);
  wire        tx_now    = (st_q == ST_FIELD) && (phase >= PH_TXS);
  wire        bit_end   = bit_q && (cnt_q == BIT_END);
  wire        fdone     = bit_end && (nbits_q == 5'h01);
  wire        dly_end   = (st_q == ST_DELAY) && (cnt_q == DELAY_CYC - 8'h01);
  wire        adv       = fdone | dly_end;
  wire        rx_done   = fdone && (st_q == ST_FIELD) && !tx_now;
  // a field ending as its slot opens is not latched yet, so take it from the shifter
  wire [15:0] addr_now  = (rx_done && (phase == PH_RXA)) ? sh_q : addr_q;
  wire [15:0] data_now  = (rx_done && (phase != PH_RXA)) ? sh_q : data_q;
  wire [7:0]  ncmd      = (st_q == ST_CODE) ? sh_q[7:0] : cmd_q;
  wire [2:0]  nstep     = (st_q == ST_CODE) ? 3'h0 : step_q + 3'h1;
  wire [2:0]  nph       = cmd_phase(ncmd, nstep);
  wire        idle      = (st_q == ST_CODE) && !bit_q && (nbits_q == 5'h08);
  wire        in_sync   = (st_q == ST_SYNCW) || (st_q == ST_SYNCH) ||
                          (st_q == ST_SYNCL) || (st_q == ST_SYNCP);
  wire        timeout   = (tmo_q == TIMEOUT_CYC);
  // own drive is never longer than a bit outside the probe answer, which in_sync masks, so only the host can trip this
  wire        sync_det  = !in_sync && !pin_oe && !pin_s_q &&
                          (low_q == SYNC_DETECT - 8'h01);
  wire [7:0]  stat_rd   = {stat_q[STAT_ENABLE_BIT], cpu_halted, stat_q[5:0]};

  // access decode, taken when a delay slot opens, or for E8 when its status field opens
  wire        act       = adv && (nph == PH_DLY) &&
                          (!halted_only(ncmd) || cpu_halted);
  wire        e8_read   = adv && (nph == PH_TXS) && (nstep == 3'h0) &&
                          (ncmd == CMD_REFETCH_S);
  wire        inc_go    = act && ((ncmd == CMD_FETCH_INC) || (ncmd == CMD_FETCH_INC_S) ||
                                  (ncmd == CMD_STORE_INC) || (ncmd == CMD_STORE_INC_S));
  wire        rd_go     = e8_read || inc_go && ncmd[5] ||
                          act && ((ncmd == CMD_MEM_FETCH) || (ncmd == CMD_MEM_FETCH_S));
  wire        wr_go     = inc_go && !ncmd[5] ||
                          act && ((ncmd == CMD_MEM_STORE) || (ncmd == CMD_MEM_STORE_S));
  wire [15:0] hx_inc    = cpu_hx + 16'h0001;
  wire [15:0] go_addr   = inc_go ? hx_inc : (e8_read ? last_q : addr_now);
  wire        set_go    = act && (ncmd[7:4] == 4'h4);
  wire [2:0]  set_sel   = (ncmd[3:0] == 4'h8) ? REG_ACC :
                          (ncmd[3:0] == 4'h9) ? REG_FLAGS :
                          (ncmd[3:0] == 4'hB) ? REG_PC :
                          (ncmd[3:0] == 4'hC) ? REG_IDX : REG_SP;
  wire        get_go    = act && (ncmd[7:4] == 4'h6);
  wire [15:0] reg_rd    = (ncmd[3:0] == 4'h8) ? {8'h00, cpu_acc} :
                          (ncmd[3:0] == 4'h9) ? {8'h00, cpu_flags} :
                          (ncmd[3:0] == 4'hB) ? cpu_pc :
                          (ncmd[3:0] == 4'hC) ? cpu_hx : cpu_sp;
  // word loaded into the shifter when an outgoing field starts
  wire [15:0] tx_word   = (nph == PH_TXS) ? {stat_rd, 8'h00} :
                          (nph == PH_TX8) ? {res_q[7:0], 8'h00} :
                          (ncmd == CMD_MATCH_GET) ? match_q : res_q;
  wire        wide      = (nph == PH_RXA) || (nph == PH_RX16) || (nph == PH_TX16);

  // bit engine and command sequencer
  always_comb
  begin
    st_d    = st_q;
    cmd_d   = cmd_q;
    step_d  = step_q;
    nbits_d = nbits_q;
    bit_d   = bit_q;
    cnt_d   = cnt_q + 8'h01;
    sh_d    = sh_q;
    oe_d    = 1'b0;
    out_d   = 1'b0;
    case (st_q)
      ST_CODE, ST_FIELD:
      begin
        if (!bit_q && fell)
        begin
          bit_d = 1'b1;
          cnt_d = 8'h00;
        end
        if (bit_q && !tx_now && (cnt_q == RX_SAMPLE))
          sh_d = {sh_q[14:0], pin_s_q};
        if (bit_q && tx_now && !sh_q[15])
        begin
          oe_d  = (cnt_q <= TX0_LOW);
          out_d = (cnt_q == TX0_LOW);
        end
        if (bit_q && tx_now && sh_q[15])
        begin
          oe_d  = (cnt_q == TX1_SPEEDUP);
          out_d = (cnt_q == TX1_SPEEDUP);
        end
        if (bit_end)
        begin
          bit_d   = 1'b0;
          nbits_d = nbits_q - 5'h01;
          if (tx_now)
            sh_d = {sh_q[14:0], 1'b0};
        end
      end
      ST_DELAY: ;
      ST_SYNCW:
        if (pin_s_q)
        begin
          st_d  = ST_SYNCH;
          cnt_d = 8'h00;
        end
      ST_SYNCH:
        if (cnt_q == SYNC_HOLD - 8'h01)
        begin
          st_d  = ST_SYNCL;
          cnt_d = 8'h00;
        end
      ST_SYNCL:
      begin
        oe_d = 1'b1;
        if (cnt_q == SYNC_LOW - 8'h01)
          st_d = ST_SYNCP;
      end
      ST_SYNCP:
      begin
        oe_d  = 1'b1;
        out_d = 1'b1;
        st_d  = ST_CODE;
      end
      default: st_d = ST_CODE;
    endcase
    // a finished field or delay opens the next phase of the command
    if (adv)
    begin
      cmd_d  = ncmd;
      step_d = nstep;
      cnt_d  = 8'h00;
      case (nph)
        PH_END:
        begin
          st_d    = ST_CODE;
          nbits_d = 5'h08;
        end
        PH_DLY:  st_d = ST_DELAY;
        default:
        begin
          st_d    = ST_FIELD;
          nbits_d = wide ? 5'h10 : 5'h08;
          sh_d    = tx_word;
        end
      endcase
    end
    // probe and timeout both drop the command with no side effect
    if (timeout || sync_det)
    begin
      st_d    = sync_det ? ST_SYNCW : ST_CODE;
      step_d  = 3'h0;
      nbits_d = 5'h08;
      bit_d   = 1'b0;
      cnt_d   = 8'h00;
      oe_d    = 1'b0;
      out_d   = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      st_q    <= ST_CODE;
      cmd_q   <= 8'h00;
      step_q  <= 3'h0;
      nbits_q <= 5'h08;
      bit_q   <= 1'b0;
      cnt_q   <= 8'h00;
      sh_q    <= 16'h0000;
      pin_oe  <= 1'b0;
      pin_out <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cmd_q   <= cmd_d;
      step_q  <= step_d;
      nbits_q <= nbits_d;
      bit_q   <= bit_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      pin_oe  <= oe_d;
      pin_out <= out_d;
    end

  // edge-to-edge watchdog and long-low detector; idle between commands never times out
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      tmo_q <= 10'h000;
      low_q <= 8'h00;
    end
    else
    begin
      tmo_q <= (fell || idle || in_sync || timeout) ? 10'h000 : tmo_q + 10'h001;
      low_q <= (pin_s_q || in_sync) ? 8'h00 :
               (low_q == SYNC_DETECT) ? low_q : low_q + 8'h01;
    end

  // memory port; the memory must answer inside the slot or field that follows
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
      last_q    <= 16'h0000;
    end
    else if (rd_go || wr_go)
    begin
      mem_req   <= 1'b1;
      mem_we    <= wr_go;
      mem_addr  <= go_addr;
      mem_wdata <= data_now[7:0];
      if (rd_go)
        last_q <= go_addr;
    end
    else if (mem_ack)
      mem_req <= 1'b0;

  // incoming fields and outgoing results
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      res_q  <= 16'h0000;
    end
    else
    begin
      if (rx_done && (phase == PH_RXA))
        addr_q <= sh_q;
      if (rx_done && (phase != PH_RXA))
        data_q <= sh_q;
      if (get_go)
        res_q <= reg_rd;
      else if (mem_req && mem_ack && !mem_we)
        res_q <= {8'h00, mem_rdata};
    end

  // processor control strobes
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      halt_req  <= 1'b0;
      go_req    <= 1'b0;
      step_req  <= 1'b0;
      reg_wr    <= 1'b0;
      reg_sel   <= REG_ACC;
      reg_wdata <= 16'h0000;
    end
    else
    begin
      halt_req  <= act && (ncmd == CMD_HALT) && stat_q[STAT_ENABLE_BIT];
      go_req    <= act && ((ncmd == CMD_RESUME) || (ncmd == CMD_RESUME_TAG));
      step_req  <= act && (ncmd == CMD_STEP);
      reg_wr    <= set_go || inc_go;
      reg_sel   <= inc_go ? REG_IDX : set_sel;
      reg_wdata <= inc_go ? hx_inc : data_now;
    end

  // host-visible debug registers
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      stat_q     <= STAT_RESET;
      match_q    <= MATCH_RESET;
      ack_enable <= 1'b0;
    end
    else
    begin
      if (rx_done && (cmd_q == CMD_CTRL_SET))
        stat_q <= sh_q[7:0];
      if (rx_done && (cmd_q == CMD_MATCH_SET))
        match_q <= sh_q;
      if (act && (ncmd == CMD_ACK_ON))
        ack_enable <= 1'b1;
      else if (act && (ncmd == CMD_ACK_OFF))
        ack_enable <= 1'b0;
    end

  // register outputs; halted flag is folded in live on reads only
  assign status_ctrl = stat_q;
  assign match_addr  = match_q;

endmodule

// File: tb/swdcl_host.sv
`timescale 1ns/100ps

// debug pod model: opens every bit, drives only low or a short speedup
module swdcl_host (
  input  wire logic clk,   // debug clock
  input  wire logic pin,   // resolved wire level
  output logic      h_oe,  // pod drives the wire
  output logic      h_out  // pod drive level
);
  initial h_oe = 1'b0;
  initial h_out = 1'b0;

  // 20 clocks per bit leaves room for the target's sync lag
  task automatic bit_io(input logic b, output logic s);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      h_oe <= (i < (b ? 3 : 15));
      if (i == 12)
        s = pin;
    end
  endtask

  // release while receiving by sending ones
  task automatic xfer(input int n, input logic [15:0] v, output logic [15:0] r);
    r = 16'h0000;
    for (int k = n - 1; k >= 0; k--)
      bit_io(v[k], r[k]);
  endtask

  task automatic slot;
    repeat (24) @(posedge clk);
  endtask

  // long low, speedup, release, then time the answer
  task automatic probe(output int lo);
    lo = 0;
    @(posedge clk) h_oe <= 1'b1;
    repeat (140) @(posedge clk);
    h_out <= 1'b1;
    @(posedge clk) h_oe <= 1'b0;
    h_out <= 1'b0;
    repeat (400) @(posedge clk) lo += !pin;
  endtask
endmodule

// File: tb/swdcl_cmd_layer_properties.sv
`timescale 1ns/100ps

module swdcl_checker (
  input wire logic        clk,         // debug clock
  input wire logic        reset,       // async reset
  input wire logic        pin_oe,      // target drives
  input wire logic        pin_out,     // target level
  input wire logic        mem_req,     // access request
  input wire logic        mem_ack,     // access done
  input wire logic        mem_we,      // write
  input wire logic [15:0] mem_addr,    // address
  input wire logic        cpu_halted,  // halted
  input wire logic        halt_req,    // halt pulse
  input wire logic        go_req,      // resume pulse
  input wire logic        step_req,    // step pulse
  input wire logic        reg_wr,      // reg write
  input wire logic [2:0]  reg_sel,     // reg select
  input wire logic [7:0]  status_ctrl  // status reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] low_n;
  wire        drv_low = pin_oe && !pin_out;

  // length of the last target low drive; only 13 or 128 are legal
  always_ff @(posedge clk or posedge reset)
    if (reset)
      low_n <= 8'h00;
    else
      low_n <= drv_low ? low_n + 8'h01 : 8'h00;

  property p_low_len; $fell(drv_low) |-> (low_n == 8'h0D || low_n == 8'h80); endproperty
  a_low_len: assert property (p_low_len) else $error("bad low drive length");
  property p_speedup; $fell(drv_low) |-> pin_oe && pin_out; endproperty
  a_speedup: assert property (p_speedup) else $error("no speedup after low");
  property p_release; pin_oe && pin_out |=> !pin_oe; endproperty
  a_release: assert property (p_release) else $error("speedup not one cycle");
  property p_mem_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request dropped early");
  property p_halt_en; halt_req |-> status_ctrl[7]; endproperty
  a_halt_en: assert property (p_halt_en) else $error("halt while disabled");
  property p_halt_pulse; halt_req |=> !halt_req; endproperty
  a_halt_pulse: assert property (p_halt_pulse) else $error("halt pulse too long");
  property p_run_halted; go_req || step_req |-> cpu_halted; endproperty
  a_run_halted: assert property (p_run_halted) else $error("resume while running");
  property p_reg_wr; reg_wr |-> cpu_halted && reg_sel <= 3'h4; endproperty
  a_reg_wr: assert property (p_reg_wr) else $error("bad register write");
endmodule

bind swdcl_cmd_layer swdcl_checker chk_i (.clk(clk), .reset(reset), .pin_oe(pin_oe),
  .pin_out(pin_out), .mem_req(mem_req), .mem_ack(mem_ack), .mem_we(mem_we),
  .mem_addr(mem_addr), .cpu_halted(cpu_halted), .halt_req(halt_req), .go_req(go_req),
  .step_req(step_req), .reg_wr(reg_wr), .reg_sel(reg_sel), .status_ctrl(status_ctrl));

// File: tb/tb.sv
`timescale 1ns/100ps

module tb;
  import swdcl_pkg::*;
  logic        clk, reset, h_oe, h_out, pin_out, pin_oe, mem_req, mem_we, mem_ack;
  logic        cpu_halted, halt_req, go_req, step_req, reg_wr, ack_en;
  logic [7:0]  mem_wdata, mem_rdata, status_ctrl;
  logic [15:0] mem_addr, reg_wdata, match_addr, r;
  logic [2:0]  reg_sel;
  logic [18:0] wr_log;
  logic [7:0]  mem [0:65535];
  int          n_mismatch = 0, total_checks = 0, n_halt = 0, n_wr = 0, n_step = 0, lo;
  // open-drain wire with pull-up
  wire         pin = h_oe ? h_out : (pin_oe ? pin_out : 1'b1);

  swdcl_host host (.clk(clk), .pin(pin), .h_oe(h_oe), .h_out(h_out));
  swdcl_cmd_layer dut (.clk(clk), .reset(reset), .pin_in(pin), .pin_out(pin_out),
    .pin_oe(pin_oe), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .cpu_halted(cpu_halted), .cpu_acc(8'h5A), .cpu_flags(8'h11), .cpu_pc(16'h0100),
    .cpu_hx(16'h0200), .cpu_sp(16'h00FF), .halt_req(halt_req), .go_req(go_req),
    .step_req(step_req), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .status_ctrl(status_ctrl), .match_addr(match_addr), .ack_enable(ack_en));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // memory answers next cycle; processor follows halt and resume pulses
  always @(posedge clk)
  begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem[mem_addr];
    if (mem_req && mem_we && !mem_ack)
      mem[mem_addr] <= mem_wdata;
    n_wr <= n_wr + (mem_req && mem_we && !mem_ack);
    n_halt <= n_halt + halt_req;
    n_step <= n_step + step_req;
    cpu_halted <= halt_req ? 1'b1 : go_req ? 1'b0 : cpu_halted;
    if (reg_wr)
      wr_log <= {reg_sel, reg_wdata};
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input int n, input logic [15:0] v);
    host.xfer(8, {8'h00, c}, r);
    host.xfer(n, v, r);
  endtask

  task automatic t_halt;
    cmd(CMD_STAT_GET, 8, 16'hFFFF);
    chk(r, 16'h0000);
    cmd(CMD_ACK_ON, 0, 16'h0000);
    host.slot;
    chk({15'h0000, ack_en}, 16'h0001);
    cmd(CMD_ACK_OFF, 0, 16'h0000);
    host.slot;
    chk({15'h0000, ack_en}, 16'h0000);
    cmd(CMD_HALT, 0, 16'h0000);
    host.slot;
    chk(n_halt[15:0], 16'h0000);
    cmd(CMD_CTRL_SET, 8, 16'h0080);
    chk({8'h00, status_ctrl}, 16'h0080);
    cmd(CMD_HALT, 0, 16'h0000);
    host.slot;
    chk(n_halt[15:0], 16'h0001);
  endtask

  task automatic t_mem;
    cmd(CMD_MEM_STORE, 16, 16'h1234);
    host.xfer(8, 16'h00A5, r);
    host.slot;
    chk({8'h00, mem[16'h1234]}, 16'h00A5);
    cmd(CMD_MEM_FETCH_S, 16, 16'h1234);
    host.slot;
    host.xfer(8, 16'hFFFF, r);
    chk(r, 16'h00C0);
    host.xfer(8, 16'hFFFF, r);
    chk(r, 16'h00A5);
    cmd(CMD_REFETCH_S, 8, 16'hFFFF);
    chk(r, 16'h00C0);
    host.xfer(8, 16'hFFFF, r);
    chk(r, 16'h00A5);
  endtask

  task automatic t_regs;
    cmd(CMD_MATCH_SET, 16, 16'hBEEF);
    cmd(CMD_MATCH_GET, 16, 16'hFFFF);
    chk(match_addr, 16'hBEEF);
    chk(r, 16'hBEEF);
    cmd(CMD_GET_ACC, 0, 16'h0000);
    host.slot;
    host.xfer(8, 16'hFFFF, r);
    chk(r, 16'h005A);
    cmd(CMD_SET_PC, 16, 16'h2468);
    host.slot;
    chk(wr_log[15:0], 16'h2468);
    chk({13'h0000, wr_log[18:16]}, {13'h0000, REG_PC});
    cmd(CMD_STEP, 0, 16'h0000);
    host.slot;
    chk(n_step[15:0], 16'h0001);
    cmd(CMD_RESUME, 0, 16'h0000);
    host.slot;
    cmd(CMD_SET_ACC, 8, 16'h0077);
    host.slot;
    chk(wr_log[15:0], 16'h2468);
  endtask

  task automatic t_abort;
    cmd(CMD_MEM_STORE, 8, 16'h0012);
    repeat (600) @(posedge clk);
    cmd(CMD_STAT_GET, 8, 16'hFFFF);
    chk(r, 16'h0080);
    chk(n_wr[15:0], 16'h0001);
    host.probe(lo);
    chk(lo[15:0], 16'h0080);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    mem_ack = 1'b0;
    cpu_halted = 1'b0;
    wr_log = 19'h00000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_halt;
    t_mem;
    t_regs;
    t_abort;
    wrap_up;
  end

  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule
